// ---- dram_mode_pkg.sv ----
// constants, field layout and carrier types of the mode word zero decode block
package dram_mode_pkg;
   localparam int MODE_W = 19;
   localparam int COL_W = 10;
   localparam int BEAT_W = 3;
   localparam int LAT_W = 5;

   // -----------------------------------------------------------------
   // field positions in mode_config_zero
   // -----------------------------------------------------------------
   localparam int BL_LO = 0;
   localparam int BL_HI = 1;
   localparam int CL_EXT_BIT = 2;
   localparam int ORDER_BIT = 3;
   localparam int CL_LO = 4;
   localparam int CL_HI = 6;
   localparam int DLL_RST_BIT = 8;
   localparam int WR_LO = 9;
   localparam int WR_HI = 11;
   localparam int PD_BIT = 12;
   localparam int SEL_LO = 16;
   localparam int SEL_HI = 17;

   localparam logic [MODE_W-1:0] MODE_RESET = 19'h00000;
   localparam logic [1:0] SEL_WORD0 = 2'h0;

   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_CHOP4 = 2'h2;

   localparam logic [LAT_W-1:0] CL_BASE_LOW = 5'h04;
   localparam logic [LAT_W-1:0] CL_BASE_HIGH = 5'h0C;
   localparam logic [LAT_W-1:0] CL_MIN = 5'h05;
   localparam logic [LAT_W-1:0] CL_MAX = 5'h0E;

   localparam logic [BEAT_W-1:0] LAST_BEAT = 3'h7;
   localparam logic [BEAT_W-1:0] CHOP_LAST = 3'h3;

   // lock wait is a plain clock count, not a time
   localparam logic [9:0] DLL_LOCK_CYCLES = 10'h200;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic mode_set;
      logic read;
      logic write;
      logic on_the_fly_length_bit;
      logic [COL_W-1:0] col;
      logic [MODE_W-1:0] word;
   } cmd_t;

   typedef struct packed {
      logic valid;
      logic rd;
      logic drive;
      logic wr_en;
      logic chop_four_burst;
      logic [BEAT_W-1:0] idx;
      logic [COL_W-1:0] col;
   } beat_t;

   typedef struct packed {
      logic [LAT_W-1:0] read_latency;
      logic [LAT_W-1:0] write_recovery;
      logic burst_ordering;
      logic precharge_powerdown_dll_option;
      logic illegal;
   } cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_BURST = 2'b10
   } state_t;
endpackage

// ---- dram_mode_word0_burst_decode.sv ----
// mode word zero register, dll reset wait and burst column ordering
`timescale 1ns/1ps

//
// Contract
// - field 01: on-the-fly bit picks chop or eight
// - block from upper bits, low bits start
// - columns wrap inside block, never cross
// - bit 3 picks sequential or interleaved
// - chop sequential read rotates nibble, then Z
// - chop interleaved read is start xor beat
// - chop write ascending nibble, low bits ignored
// - eight sequential read rotates both nibbles
// - eight interleaved read is start xor beat
// - eight write always columns zero to seven
// - chop and eight start at same time
// - bit 8 starts dll reset, self-clears
// - bits 11:9 set write recovery cycles
// - bit 12 stops or keeps dll in powerdown
// - read latency from bits 6:4 plus extension bit 2, 5..14
// - first read data at edge n plus m
module dram_mode_word0_burst_decode
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire dram_mode_pkg::cmd_t i_cmd,
   input wire logic i_cke,
   input wire logic i_pd_active,
   output dram_mode_pkg::beat_t o_beat,
   output dram_mode_pkg::cfg_t o_cfg,
   output logic o_dll_locked,
   output logic o_dll_run,
   output logic o_busy
);
   import dram_mode_pkg::*;

   // -----------------------------------------------------------------
   // decode functions
   // -----------------------------------------------------------------
   function automatic logic [LAT_W-1:0] wr_decode(input logic [2:0] code);
      logic [LAT_W-1:0] r;
      r = 5'h10;
      unique case (code)
         3'h1: r = 5'h05;
         3'h2: r = 5'h06;
         3'h3: r = 5'h07;
         3'h4: r = 5'h08;
         3'h5: r = 5'h0A;
         3'h6: r = 5'h0C;
         3'h7: r = 5'h0E;
         3'h0: r = 5'h10;
      endcase
      return r;
   endfunction

   // extension bit lifts the three-bit code into the upper range
   function automatic logic [LAT_W-1:0] cl_decode(input logic [2:0] code, input logic ext);
      logic [LAT_W-1:0] base;
      base = ext ? CL_BASE_HIGH : CL_BASE_LOW;
      return base + {2'h0, code};
   endfunction

   function automatic logic chop_pick(input logic [1:0] bl, input logic otf);
      logic r;
      r = 1'b0;
      unique case (bl)
         BL_FIXED8: r = 1'b0;
         BL_OTF: r = ~otf;
         BL_CHOP4: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // column low bits for a beat; the upper column bits never change
   function automatic logic [2:0] beat_col(input logic [2:0] s, input logic [2:0] b,
                                           input logic ilv, input logic wr, input logic chop);
      logic [2:0] r;
      if (wr)
         r = chop ? {s[2], b[1:0]} : b;
      else if (ilv)
         r = chop ? (s ^ {1'b0, b[1:0]}) : (s ^ b);
      else
         // a chop keeps its nibble even in the idle tail slots
         r = {s[2] ^ (b[2] & ~chop), s[1:0] + b[1:0]};
      return r;
   endfunction

   // -----------------------------------------------------------------
   // mode word zero
   // -----------------------------------------------------------------
   logic [MODE_W-1:0] mode_reg;
   logic word0_hit;
   logic cl_bad;
   logic [LAT_W-1:0] cl_val;

   assign word0_hit = i_cmd.mode_set && (i_cmd.word[SEL_HI:SEL_LO] == SEL_WORD0);
   assign cl_val = cl_decode(mode_reg[CL_HI:CL_LO], mode_reg[CL_EXT_BIT]);
   assign cl_bad = (cl_val < CL_MIN) || (cl_val > CL_MAX);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         mode_reg <= MODE_RESET;
      else if (word0_hit)
         mode_reg <= i_cmd.word & ~(19'h00001 << DLL_RST_BIT);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_cfg <= '0;
      else
      begin
         o_cfg.read_latency <= cl_val;
         o_cfg.write_recovery <= wr_decode(mode_reg[WR_HI:WR_LO]);
         o_cfg.burst_ordering <= mode_reg[ORDER_BIT];
         o_cfg.precharge_powerdown_dll_option <= mode_reg[PD_BIT];
         o_cfg.illegal <= cl_bad || (mode_reg[BL_HI:BL_LO] == 2'h3);
      end
   end

   // dll stops in precharge powerdown only when the option bit is clear
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_dll_run <= 1'b0;
      else
         o_dll_run <= !(i_pd_active && !mode_reg[PD_BIT]);
   end

   // -----------------------------------------------------------------
   // dll reset and lock wait
   // -----------------------------------------------------------------
   logic [9:0] lock_cnt;

   // the wait only advances while clock enable is held high
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         lock_cnt <= '0;
      else if (word0_hit && i_cmd.word[DLL_RST_BIT])
         lock_cnt <= DLL_LOCK_CYCLES;
      else if (lock_cnt != '0 && i_cke)
         lock_cnt <= lock_cnt - 10'h001;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_dll_locked <= 1'b0;
      else if (word0_hit && i_cmd.word[DLL_RST_BIT])
         o_dll_locked <= 1'b0;
      else
         o_dll_locked <= (lock_cnt == 10'h001 && i_cke) || (lock_cnt == '0 && o_dll_locked);
   end

   // -----------------------------------------------------------------
   // burst sequencer
   // -----------------------------------------------------------------
   state_t state_reg;
   logic [LAT_W-1:0] wait_reg;
   logic [BEAT_W-1:0] idx_reg;
   logic [COL_W-1:0] start_reg;
   logic rd_reg;
   logic chop_reg;
   logic ilv_reg;
   logic take;
   logic [BEAT_W-1:0] idx_next;
   logic [2:0] col_next;
   logic emit;

   // a command arriving while a burst is in flight is dropped
   assign take = (state_reg == ST_IDLE) && (i_cmd.read || i_cmd.write);
   assign emit = (state_reg == ST_WAIT && wait_reg == 5'h01) || (state_reg == ST_BURST);
   assign idx_next = (state_reg == ST_BURST) ? idx_reg + 3'h1 : 3'h0;
   assign col_next = beat_col(start_reg[2:0], idx_next, ilv_reg, !rd_reg, chop_reg);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         state_reg <= ST_IDLE;
      else
      begin
         unique case (state_reg)
            ST_IDLE:
               if (take)
                  state_reg <= ST_WAIT;
            ST_WAIT:
               if (wait_reg == 5'h01)
                  state_reg <= ST_BURST;
            ST_BURST:
               if (idx_reg == LAST_BEAT - 3'h1)
                  state_reg <= ST_IDLE;
         endcase
      end
   end

   // chop runs the same eight slots as a full burst, so start time matches
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         wait_reg <= '0;
      else if (take)
         wait_reg <= o_cfg.read_latency;
      else if (state_reg == ST_WAIT)
         wait_reg <= wait_reg - 5'h01;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         start_reg <= '0;
         rd_reg <= 1'b0;
         chop_reg <= 1'b0;
         ilv_reg <= 1'b0;
      end
      else if (take)
      begin
         start_reg <= i_cmd.col;
         rd_reg <= i_cmd.read;
         chop_reg <= chop_pick(mode_reg[BL_HI:BL_LO], i_cmd.on_the_fly_length_bit);
         ilv_reg <= mode_reg[ORDER_BIT];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         idx_reg <= '0;
      else if (emit)
         idx_reg <= idx_next;
   end

   // upper column bits come from the command unchanged, so the burst wraps
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_beat <= '0;
      else
      begin
         o_beat.valid <= emit;
         o_beat.rd <= emit && rd_reg;
         o_beat.drive <= emit && rd_reg && !(chop_reg && idx_next > CHOP_LAST);
         o_beat.wr_en <= emit && !rd_reg && !(chop_reg && idx_next > CHOP_LAST);
         o_beat.chop_four_burst <= chop_reg;
         o_beat.idx <= idx_next;
         o_beat.col <= {start_reg[COL_W-1:3], col_next};
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_busy <= 1'b0;
      else
         o_busy <= (state_reg != ST_IDLE && !(state_reg == ST_BURST && idx_reg == LAST_BEAT - 3'h1)) || take;
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [LAT_W:0] since_take;

   always_ff @(posedge i_clk)
   begin
      if (i_rst || take)
         since_take <= '0;
      else if (state_reg == ST_WAIT)
         since_take <= since_take + 6'h01;
   end

   a_rl_first_beat: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_beat.valid) |-> since_take == {1'b0, o_cfg.read_latency})
      else $error("first beat not at latency");

   a_eight_slots: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_beat.valid) |-> o_beat.valid[*8] ##1 !o_beat.valid)
      else $error("burst did not take eight slots");

   a_chop_tristate: assert property (@(posedge i_clk) disable iff (i_rst)
      o_beat.valid && o_beat.chop_four_burst && o_beat.idx > CHOP_LAST |-> !o_beat.drive && !o_beat.wr_en)
      else $error("chop tail not idle");

   a_block_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
      o_beat.valid |-> o_beat.col[COL_W-1:3] == start_reg[COL_W-1:3]
         && (!o_beat.chop_four_burst || o_beat.rd == 1'b0 || o_beat.col[2] == start_reg[2]))
      else $error("burst left its block");

   a_interleave_order: assert property (@(posedge i_clk) disable iff (i_rst)
      o_beat.rd && ilv_reg && !o_beat.chop_four_burst |-> o_beat.col[2:0] == (start_reg[2:0] ^ o_beat.idx))
      else $error("interleaved order wrong");

   a_seq_order: assert property (@(posedge i_clk) disable iff (i_rst)
      o_beat.rd && !ilv_reg |-> o_beat.col[1:0] == start_reg[1:0] + o_beat.idx[1:0])
      else $error("sequential rotation wrong");

   a_write_ascend: assert property (@(posedge i_clk) disable iff (i_rst)
      o_beat.valid && !o_beat.rd && !o_beat.chop_four_burst |-> o_beat.col[2:0] == o_beat.idx)
      else $error("eight write not ascending");

   a_chop_write: assert property (@(posedge i_clk) disable iff (i_rst)
      o_beat.wr_en && o_beat.chop_four_burst |-> o_beat.col[2:0] == {start_reg[2], o_beat.idx[1:0]})
      else $error("chop write order wrong");

   a_dll_self_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      word0_hit && i_cmd.word[DLL_RST_BIT] |=> !mode_reg[DLL_RST_BIT] && !o_dll_locked ##1 !o_dll_locked)
      else $error("dll reset not self-clearing");

   a_pd_dll_stop: assert property (@(posedge i_clk) disable iff (i_rst)
      i_pd_active && !mode_reg[PD_BIT] |=> !o_dll_run)
      else $error("dll kept running in powerdown");

   a_otf_pick: assert property (@(posedge i_clk) disable iff (i_rst)
      take && mode_reg[BL_HI:BL_LO] == BL_OTF |=> chop_reg == !$past(i_cmd.on_the_fly_length_bit))
      else $error("on-the-fly length misread");

   a_chop_interleave: assert property (@(posedge i_clk) disable iff (i_rst)
      o_beat.drive && o_beat.chop_four_burst && ilv_reg |-> o_beat.col[2:0] == (start_reg[2:0] ^ {1'b0, o_beat.idx[1:0]}))
      else $error("chop interleaved order wrong");

   a_lock_hold_cke: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_cke && lock_cnt != '0 && !(word0_hit && i_cmd.word[DLL_RST_BIT]) |=> lock_cnt == $past(lock_cnt))
      else $error("lock wait advanced with clock enable low");

   a_wr_range: assert property (@(posedge i_clk) disable iff (i_rst)
      mode_reg[WR_HI:WR_LO] != 3'h0 |=> o_cfg.write_recovery >= 5'h05 && o_cfg.write_recovery <= 5'h0E)
      else $error("write recovery out of range");

   a_latency_range: assert property (@(posedge i_clk) disable iff (i_rst)
      !cl_bad |=> o_cfg.read_latency >= CL_MIN && o_cfg.read_latency <= CL_MAX)
      else $error("read latency out of range");

   a_busy_drop: assert property (@(posedge i_clk) disable iff (i_rst)
      o_busy && (i_cmd.read || i_cmd.write) |=> $stable(start_reg) && $stable(rd_reg))
      else $error("command taken while busy");
endmodule

// ---- dram_ctrl_model.sv ----
// controller model that issues mode-set and column commands to the decode block
`timescale 1ns/1ps
module dram_ctrl_model
(
   input wire logic i_clk,
   input wire logic i_busy,
   input wire logic i_locked,
   output dram_mode_pkg::cmd_t o_cmd,
   output logic o_cke
);
   import dram_mode_pkg::*;
   int stalls = 0;

   initial
   begin
      o_cmd = '0;
      o_cke = 1'b1;
   end

   // released lines flip to the inverse so a stale copy is never mistaken for a command
   task automatic idle();
      o_cmd = '{1'b0, 1'b0, 1'b0, ~o_cmd.on_the_fly_length_bit, ~o_cmd.col, ~o_cmd.word};
   endtask

   task automatic pulse(input cmd_t c);
      o_cmd = c;
      @(posedge i_clk);
      #1;
      idle();
   endtask

   // bounded wait; a wait that runs out is counted and checked by the bench
   task automatic settle(input bit lock);
      int n;
      n = 0;
      while ((lock ? i_locked !== 1'b1 : i_busy !== 1'b0) && n < 600)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
      if (n == 600)
         stalls++;
   endtask

   task automatic mode_set(input logic [MODE_W-1:0] w);
      settle(1'b0);
      pulse('{1'b1, 1'b0, 1'b0, 1'b0, '0, w});
   endtask

   task automatic column(input logic rd, input logic otf, input logic [COL_W-1:0] col);
      if (rd)
         settle(1'b1);
      pulse('{1'b0, rd, !rd, otf, col, '0});
   endtask

   task automatic set_cke(input logic v);
      o_cke = v;
   endtask
endmodule

// ---- dram_mode_word0_burst_decode_test.sv ----
// self-checking bench for the mode word zero decode block
`timescale 1ns/1ps
module dram_mode_word0_burst_decode_test;
   import dram_mode_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_pd_active = 1'b0;
   logic i_cke;
   cmd_t i_cmd;
   beat_t o_beat;
   cfg_t o_cfg;
   logic o_dll_locked;
   logic o_dll_run;
   logic o_busy;
   int mismatches = 0;
   int comparisons = 0;

   initial
   begin
      forever #2 i_clk = ~i_clk;
   end

   dram_mode_word0_burst_decode dut(.i_clk(i_clk), .i_rst(i_rst), .i_cmd(i_cmd), .i_cke(i_cke),
      .i_pd_active(i_pd_active), .o_beat(o_beat), .o_cfg(o_cfg), .o_dll_locked(o_dll_locked),
      .o_dll_run(o_dll_run), .o_busy(o_busy));
   dram_ctrl_model ctrl(.i_clk(i_clk), .i_busy(o_busy), .i_locked(o_dll_locked), .o_cmd(i_cmd), .o_cke(i_cke));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      check(ctrl.stalls, 0);
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   function automatic logic [3:0] cl_of(input int m);
      return (m < 12) ? {1'b0, 3'(m - 4)} : {1'b1, 3'(m - 12)};
   endfunction

   function automatic logic [18:0] mk(input logic [1:0] bl, input logic ilv, input logic [3:0] cl,
                                      input logic [2:0] wr, input logic pd, input logic dll);
      return {6'h00, pd, wr, dll, 1'b0, cl[2:0], ilv, cl[3], bl};
   endfunction

   function automatic logic [2:0] exp_low(input logic rd, input logic ilv, input logic chop,
                                          input logic [2:0] s, input logic [2:0] i);
      if (!rd)
         return chop ? {s[2], i[1:0]} : i;
      if (ilv)
         return s ^ i;
      return {s[2] ^ i[2], s[1:0] + i[1:0]};
   endfunction

   task automatic setm(input logic [18:0] w);
      ctrl.mode_set(w);
      ticks(2);
   endtask

   task automatic t_lock();
      int n;
      for (int p = 0; p < 2; p++)
      begin
         ctrl.mode_set(mk(2'h0, 1'b0, cl_of(5), 3'h1, 1'b0, 1'b1));
         if (p == 1)
         begin
            // clock enable low holds the lock count where it stands
            ctrl.set_cke(1'b0);
            ticks(20);
            ctrl.set_cke(1'b1);
         end
         check(o_dll_locked, 1'b0);
         n = 1;
         while (o_dll_locked !== 1'b1 && n < 700)
         begin
            ticks(1);
            n++;
         end
         check(n, 513);
      end
      setm(mk(2'h0, 1'b0, cl_of(5), 3'h1, 1'b0, 1'b0));
      ticks(1);
      check(o_dll_locked, 1'b1);
   endtask

   task automatic t_cfg();
      logic [4:0] wrtab [7] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E};
      int cyc;
      i_pd_active = 1'b1;
      for (int k = 0; k < 10; k++)
      begin
         setm(mk(2'(k % 3), k[0], cl_of(5 + k), 3'(k % 7 + 1), k[1], 1'b0));
         check(o_cfg.read_latency, 5 + k);
         check(o_cfg.write_recovery, wrtab[k % 7]);
         check(o_cfg.burst_ordering, k[0]);
         check(o_cfg.precharge_powerdown_dll_option, k[1]);
         check(o_dll_run, k[1]);
         check(o_cfg.illegal, 1'b0);
      end
      // a mode set aimed at another word leaves this one alone
      setm(mk(2'h0, 1'b0, cl_of(5), 3'h1, 1'b0, 1'b0) | 19'h10000);
      check(o_cfg.read_latency, 5'h0E);
      setm(mk(2'h3, 1'b0, cl_of(5), 3'h1, 1'b0, 1'b0));
      check(o_cfg.illegal, 1'b1);
      setm(mk(2'h0, 1'b0, 4'h0, 3'h1, 1'b0, 1'b0));
      check(o_cfg.illegal, 1'b1);
      // a 38 ns recovery at a 4 ns clock rounds up to 10 cycles, code 101
      cyc = (38 + 4 - 1) / 4;
      setm(mk(2'h0, 1'b0, cl_of(5), 3'h5, 1'b0, 1'b0));
      check(o_cfg.write_recovery, cyc);
      i_pd_active = 1'b0;
      ticks(1);
      check(o_dll_run, 1'b1);
   endtask

   task automatic burst(input logic rd, input logic [1:0] bl, input logic ilv, input logic otf,
                        input logic [9:0] col, input int m, input bit poke);
      logic chop;
      logic act;
      logic [2:0] i;
      chop = (bl == 2'h1) ? !otf : (bl == 2'h2);
      setm(mk(bl, ilv, cl_of(m), 3'h1, 1'b0, 1'b0));
      ctrl.column(rd, otf, col);
      for (int k = 1; k <= m + 9; k++)
      begin
         // a second read while busy must be dropped without disturbing the first
         if (k == 2 && poke)
            ctrl.column(1'b1, 1'b1, 10'h000);
         else
            ticks(1);
         i = 3'(k - m);
         act = (k >= m) && (k < m + 8);
         if (k == 1)
            check(o_busy, 1'b1);
         check(o_beat.valid, act);
         if (act)
         begin
            check(o_beat.idx, i);
            check(o_beat.rd, rd);
            check(o_beat.chop_four_burst, chop);
            check({o_beat.drive, o_beat.wr_en}, (chop && i > 3) ? 2'h0 : {rd, !rd});
            if (!(chop && i > 3))
               check(o_beat.col, {col[9:3], exp_low(rd, ilv, chop, col[2:0], i)});
         end
      end
      check(o_busy, 1'b0);
   endtask

   task automatic t_bursts();
      for (int k = 0; k < 16; k++)
         burst(1'b1, k[0] ? 2'h1 : 2'h0, k[3], 1'b1, {7'h5A, 3'(k)}, 5 + k % 10, k == 3);
      for (int k = 0; k < 16; k++)
         burst(1'b1, k[0] ? 2'h2 : 2'h1, k[3], 1'b0, {7'h7F, 3'(k)}, 14 - k % 10, 1'b0);
      for (int k = 0; k < 8; k++)
         burst(1'b0, 2'(k), k[2], 1'b1, {7'h01, 3'(k * 3)}, 5 + k, 1'b0);
   endtask

   initial
   begin
      repeat (3) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      check(o_busy, 1'b0);
      check(o_beat.valid, 1'b0);
      t_lock();
      t_cfg();
      t_bursts();
      report_and_stop();
   end
endmodule
